//--- bonded_clk_pkg.sv
package bonded_clk_pkg;
	localparam int CH_N = 4;
	localparam int SRC_N = 4;
	localparam int PTR_W = 3;
	// Bonding widths
	localparam logic [1:0] BOND_NONE = 2'h0;
	localparam logic [1:0] BOND_X2 = 2'h1;
	localparam logic [1:0] BOND_X4 = 2'h2;
	localparam logic [3:0] MASK_NONE = 4'h0;
	localparam logic [3:0] MASK_X2 = 4'h3;
	localparam logic [3:0] MASK_X4 = 4'hF;
	// Source index: bit 1 set marks a PLL beyond the adjacent pair
	localparam int SRC_EXT_BIT = 1;
	// Reset values
	localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic [7:0] HSEL_RST = 8'h00;
	typedef enum logic [1:0] {
		OP_TX = 2'b00,
		OP_RX = 2'b01,
		OP_TXRX = 2'b10
	} op_mode_e;
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10
	} ctl_state_e;
endpackage

//--- bonded_channel_clocking.sv
`timescale 1ns/1ps
module bonded_channel_clocking
	import bonded_clk_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [1:0] cfg_bond_i,
	input wire logic [1:0] cfg_op_i,
	input wire logic cfg_rm_en_i,
	input wire logic cfg_ser_en_i,
	input wire logic cfg_deser_en_i,
	input wire logic cfg_big_pkg_i,
	input wire logic [1:0] cfg_lsrc_i,
	input wire logic [7:0] cfg_hsrc_i,
	input wire logic [3:0] cfg_ch_en_i,
	input wire logic [3:0] pll_tick_i,
	input wire logic [3:0] rec_ls_tick_i,
	input wire logic [3:0] rec_hs_tick_i,
	output logic running_o,
	output logic cfg_err_o,
	output logic [3:0] bonded_o,
	output logic [1:0] core_sel_o,
	output logic core_clkout_o,
	output logic [7:0] hs_sel_o,
	output logic [3:0] ser_tick_o,
	output logic [3:0] tx_pcs_tick_o,
	output logic [3:0] tx_fifo_rd_tick_o,
	output logic [3:0] tx_clkout_o,
	output logic [3:0] deser_tick_o,
	output logic [3:0] rm_wr_tick_o,
	output logic [3:0] rx_pcs_tick_o,
	output logic [3:0] rx_fifo_wr_tick_o,
	output logic [3:0] rx_clkout_o,
	output logic [11:0] tx_rd_ptr_o,
	output logic [11:0] rx_wr_ptr_o
);

////////////////////////////////////////////////////////////////////////////
// Static configuration, captured once after reset release
ctl_state_e state_r, state_nxt;
logic [1:0] bond_r, bond_nxt;
logic [1:0] op_r, op_nxt;
logic rm_r, rm_nxt;
logic ser_r, ser_nxt;
logic deser_r, deser_nxt;
logic big_r, big_nxt;
logic [1:0] lsrc_r, lsrc_nxt;
logic [7:0] hsel_r, hsel_nxt;
logic [3:0] chen_r, chen_nxt;

always_comb begin
	state_nxt = state_r;
	bond_nxt = bond_r;
	op_nxt = op_r;
	rm_nxt = rm_r;
	ser_nxt = ser_r;
	deser_nxt = deser_r;
	big_nxt = big_r;
	lsrc_nxt = lsrc_r;
	hsel_nxt = hsel_r;
	chen_nxt = chen_r;
	case (state_r)
		ST_RESET: begin
			state_nxt = ST_LOAD;
		end
		ST_LOAD: begin
			bond_nxt = cfg_bond_i;
			op_nxt = cfg_op_i;
			rm_nxt = cfg_rm_en_i;
			ser_nxt = cfg_ser_en_i;
			deser_nxt = cfg_deser_en_i;
			big_nxt = cfg_big_pkg_i;
			lsrc_nxt = cfg_lsrc_i;
			hsel_nxt = cfg_hsrc_i;
			chen_nxt = cfg_ch_en_i;
			state_nxt = ST_RUN;
		end
		ST_RUN: begin
			state_nxt = ST_RUN;
		end
		default: begin
			state_nxt = ST_RESET;
		end
	endcase
end

always_ff @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		state_r <= ST_RESET;
		bond_r <= BOND_NONE;
		op_r <= OP_TX;
		rm_r <= 1'b0;
		ser_r <= 1'b0;
		deser_r <= 1'b0;
		big_r <= 1'b0;
		lsrc_r <= SEL_RST;
		hsel_r <= HSEL_RST;
		chen_r <= MASK_NONE;
	end else begin
		state_r <= state_nxt;
		bond_r <= bond_nxt;
		op_r <= op_nxt;
		rm_r <= rm_nxt;
		ser_r <= ser_nxt;
		deser_r <= deser_nxt;
		big_r <= big_nxt;
		lsrc_r <= lsrc_nxt;
		hsel_r <= hsel_nxt;
		chen_r <= chen_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////
// Bonding legality and common low-speed path
logic run;
logic tx_on;
logic rx_on;
logic rm_on;
logic ext_ok;
logic bond_err;
logic [3:0] mask;

// Illegal setups fall back to independent channels
always_comb begin
	run = (state_r == ST_RUN);
	tx_on = (op_r != OP_RX);
	rx_on = (op_r != OP_TX);
	rm_on = rm_r && (op_r == OP_TXRX);
	ext_ok = big_r && (bond_r != BOND_X4);
	bond_err = 1'b0;
	if (bond_r != BOND_NONE && op_r == OP_RX) begin
		bond_err = 1'b1;
	end else if (bond_r == 2'h3) begin
		bond_err = 1'b1;
	end else if (lsrc_r[SRC_EXT_BIT] && bond_r != BOND_NONE && !ext_ok) begin
		bond_err = 1'b1;
	end else if (bond_r != BOND_NONE && !ext_ok && (hsel_r[SRC_EXT_BIT]
			|| hsel_r[2+SRC_EXT_BIT] || (bond_r == BOND_X4
			&& (hsel_r[4+SRC_EXT_BIT] || hsel_r[6+SRC_EXT_BIT])))) begin
		bond_err = 1'b1;
	end
	if (bond_err) begin
		mask = MASK_NONE;
	end else if (bond_r == BOND_X2) begin
		mask = MASK_X2;
	end else if (bond_r == BOND_X4) begin
		mask = MASK_X4;
	end else begin
		mask = MASK_NONE;
	end
end

logic core_tick_r, core_tick_nxt;
logic div_r, div_nxt;
logic tx_half;
logic rx_half;
logic [PTR_W-1:0] txp_r, txp_nxt;
logic [PTR_W-1:0] rxp_r, rxp_nxt;

// One selected source, one divider, one pointer set for the whole group
always_comb begin
	core_tick_nxt = run && (mask != MASK_NONE) && pll_tick_i[lsrc_r];
	div_nxt = div_r ^ core_tick_r;
	tx_half = ser_r ? (core_tick_r && div_r) : core_tick_r;
	rx_half = deser_r ? (core_tick_r && div_r) : core_tick_r;
	txp_nxt = txp_r;
	rxp_nxt = rxp_r;
	if (tx_on && tx_half) begin
		txp_nxt = txp_r + 3'h1;
	end
	if (rm_on && rx_half) begin
		rxp_nxt = rxp_r + 3'h1;
	end
end

always_ff @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		core_tick_r <= 1'b0;
		div_r <= 1'b0;
		txp_r <= PTR_RST;
		rxp_r <= PTR_RST;
	end else begin
		core_tick_r <= core_tick_nxt;
		div_r <= div_nxt;
		txp_r <= txp_nxt;
		rxp_r <= rxp_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////
// Group status outputs
always_ff @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		running_o <= 1'b0;
		cfg_err_o <= 1'b0;
		bonded_o <= MASK_NONE;
		core_sel_o <= SEL_RST;
		core_clkout_o <= 1'b0;
		hs_sel_o <= HSEL_RST;
	end else begin
		running_o <= run;
		cfg_err_o <= run && bond_err;
		bonded_o <= run ? mask : MASK_NONE;
		core_sel_o <= lsrc_r;
		core_clkout_o <= core_tick_r;
		hs_sel_o <= hsel_r;
	end
end

////////////////////////////////////////////////////////////////////////////
// Per-channel clock steering
genvar c;
generate
	for (c = 0; c < CH_N; c++) begin : g_ch
		logic own_ls;
		logic own_half;
		logic on;
		logic bnd;
		logic own_div_r, own_div_nxt;
		logic [PTR_W-1:0] otx_r, otx_nxt;
		logic [PTR_W-1:0] orx_r, orx_nxt;
		logic [PTR_W-1:0] tptr;
		logic [PTR_W-1:0] rptr;
		logic ser_nxt_c, pcs_nxt, tfifo_nxt, tclk_nxt;
		logic des_nxt, rmw_nxt, rpcs_nxt, rfifo_nxt, rclk_nxt;

		// Own source pick and TX pointer for unbonded use; local divider and RX pointer except when bonded with rate matching
		always_comb begin
			on = run && chen_r[c];
			bnd = mask[c];
			own_ls = pll_tick_i[hsel_r[2*c +: 2]];
			own_div_nxt = own_div_r ^ (rm_on ? own_ls : rec_ls_tick_i[c]);
			own_half = own_ls && (!ser_r || own_div_r);
			otx_nxt = otx_r;
			orx_nxt = orx_r;
			if (on && tx_on && own_half) begin
				otx_nxt = otx_r + 3'h1;
			end
			if (on && rx_on && !(bnd && rm_on)) begin
				if (rm_on ? (own_ls && (!deser_r || own_div_r))
					: (rec_ls_tick_i[c] && (!deser_r || own_div_r))) begin
					orx_nxt = orx_r + 3'h1;
				end
			end
			tptr = bnd ? txp_r : otx_r;
			rptr = (bnd && rm_on) ? rxp_r : orx_r;
			ser_nxt_c = on && tx_on && pll_tick_i[hsel_r[2*c +: 2]];
			pcs_nxt = on && tx_on && (bnd ? core_tick_r : own_ls);
			tfifo_nxt = on && tx_on && (bnd ? tx_half : own_half);
			tclk_nxt = on && tx_on && !bnd && own_ls;
			des_nxt = on && rx_on && rec_hs_tick_i[c];
			rmw_nxt = on && rx_on && rm_on && rec_ls_tick_i[c];
			if (rm_on) begin
				rpcs_nxt = on && rx_on && (bnd ? core_tick_r : own_ls);
				rfifo_nxt = on && rx_on && (bnd ? rx_half
					: (own_ls && (!deser_r || own_div_r)));
			end else begin
				rpcs_nxt = on && rx_on && rec_ls_tick_i[c];
				rfifo_nxt = on && rx_on && rec_ls_tick_i[c]
					&& (!deser_r || own_div_r);
			end
			rclk_nxt = on && rx_on && !rm_on && rec_ls_tick_i[c];
		end

		always_ff @(posedge clk_sys_i) begin
			if (!rst_n_i) begin
				own_div_r <= 1'b0;
				otx_r <= PTR_RST;
				orx_r <= PTR_RST;
				ser_tick_o[c] <= 1'b0;
				tx_pcs_tick_o[c] <= 1'b0;
				tx_fifo_rd_tick_o[c] <= 1'b0;
				tx_clkout_o[c] <= 1'b0;
				deser_tick_o[c] <= 1'b0;
				rm_wr_tick_o[c] <= 1'b0;
				rx_pcs_tick_o[c] <= 1'b0;
				rx_fifo_wr_tick_o[c] <= 1'b0;
				rx_clkout_o[c] <= 1'b0;
				tx_rd_ptr_o[PTR_W*c +: PTR_W] <= PTR_RST;
				rx_wr_ptr_o[PTR_W*c +: PTR_W] <= PTR_RST;
			end else begin
				own_div_r <= own_div_nxt;
				otx_r <= otx_nxt;
				orx_r <= orx_nxt;
				ser_tick_o[c] <= ser_nxt_c;
				tx_pcs_tick_o[c] <= pcs_nxt;
				tx_fifo_rd_tick_o[c] <= tfifo_nxt;
				tx_clkout_o[c] <= tclk_nxt;
				deser_tick_o[c] <= des_nxt;
				rm_wr_tick_o[c] <= rmw_nxt;
				rx_pcs_tick_o[c] <= rpcs_nxt;
				rx_fifo_wr_tick_o[c] <= rfifo_nxt;
				rx_clkout_o[c] <= rclk_nxt;
				tx_rd_ptr_o[PTR_W*c +: PTR_W] <= tptr;
				rx_wr_ptr_o[PTR_W*c +: PTR_W] <= rptr;
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Checks
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!rst_n_i);

property p_bond_skew;
	bonded_o[0] && bonded_o[1] |->
		tx_pcs_tick_o[0] == tx_pcs_tick_o[1];
endproperty
a_bond_skew: assert property (p_bond_skew) else $error("skew");

property p_ptr_shared;
	bonded_o[0] && bonded_o[1] |->
		tx_rd_ptr_o[2:0] == tx_rd_ptr_o[5:3];
endproperty
a_ptr_shared: assert property (p_ptr_shared) else $error("ptr");

property p_x2_mask;
	run && !bond_err && bond_r == BOND_X2 |=> bonded_o == MASK_X2;
endproperty
a_x2_mask: assert property (p_x2_mask) else $error("x2 mask");

property p_rx_only;
	op_r == OP_RX |=> bonded_o == MASK_NONE;
endproperty
a_rx_only: assert property (p_rx_only) else $error("rx only");

property p_core_src;
	run && mask != MASK_NONE && pll_tick_i[lsrc_r] |=> ##1 core_clkout_o;
endproperty
a_core_src: assert property (p_core_src) else $error("core");

property p_ser_half;
	bonded_o[0] && ser_r && tx_fifo_rd_tick_o[0] |=>
		!tx_fifo_rd_tick_o[0];
endproperty
a_ser_half: assert property (p_ser_half) else $error("half");

property p_rm_read;
	bonded_o[0] && rm_on && chen_r[0] |->
		rx_pcs_tick_o[0] == tx_pcs_tick_o[0];
endproperty
a_rm_read: assert property (p_rm_read) else $error("rm read");

property p_rm_write;
	run && chen_r[1] && rm_on && rec_ls_tick_i[1] |=> rm_wr_tick_o[1];
endproperty
a_rm_write: assert property (p_rm_write) else $error("rm wr");

property p_no_rm;
	run && chen_r[2] && rx_on && !rm_on && rec_ls_tick_i[2] |=>
		rx_clkout_o[2] && rx_pcs_tick_o[2];
endproperty
a_no_rm: assert property (p_no_rm) else $error("no rm");

property p_static;
	running_o |=> $stable(hs_sel_o) && $stable(core_sel_o);
endproperty
a_static: assert property (p_static) else $error("static");

c_x4: cover property (bonded_o == MASK_X4 && core_clkout_o);
c_x2_rm: cover property (bonded_o == MASK_X2 && rm_on && rx_pcs_tick_o[0]);
c_err: cover property (cfg_err_o);
c_half: cover property (deser_r && rx_fifo_wr_tick_o[0]);

endmodule

//--- fabric_model.sv
`timescale 1ns/1ps
// Fabric side: one launch and capture per exported common pulse
module fabric_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic core_clkout_i,
	output int launch_cnt_o
);
	// Count strobes taken on the exported clock
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			launch_cnt_o <= 0;
		end else if (core_clkout_i === 1'b1) begin
			launch_cnt_o <= launch_cnt_o + 1;
		end
	end
endmodule

//--- bonded_channel_clocking_tb_top.sv
`timescale 1ns/1ps
module bonded_channel_clocking_tb_top;
	logic clk_sys_i, rst_n_i, cfg_rm_en_i, cfg_ser_en_i;
	logic cfg_deser_en_i, cfg_big_pkg_i;
	logic [1:0] cfg_bond_i, cfg_op_i, cfg_lsrc_i, core_sel_o;
	logic [7:0] cfg_hsrc_i, hs_sel_o;
	logic [3:0] cfg_ch_en_i, pll_tick_i, rec_ls_tick_i, rec_hs_tick_i;
	logic running_o, cfg_err_o, core_clkout_o;
	logic [3:0] bonded_o, ser_tick_o, tx_pcs_tick_o, tx_fifo_rd_tick_o;
	logic [3:0] tx_clkout_o, deser_tick_o, rm_wr_tick_o, rx_pcs_tick_o;
	logic [3:0] rx_fifo_wr_tick_o, rx_clkout_o;
	logic [11:0] tx_rd_ptr_o, rx_wr_ptr_o;
	int fails = 0;
	int tests_run = 0;
	int launches, fn_t, fn_r;
	logic [6:0] tv [5] = '{7'h48, 7'h60, 7'h22, 7'h26, 7'h46};
	logic ev [5] = '{1, 1, 1, 0, 1};
	logic [3:0] eb [5] = '{4'h0, 4'h0, 4'h0, 4'h3, 4'h0};

	bonded_channel_clocking u_bonded_channel_clocking (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.cfg_bond_i(cfg_bond_i),
		.cfg_op_i(cfg_op_i),
		.cfg_rm_en_i(cfg_rm_en_i),
		.cfg_ser_en_i(cfg_ser_en_i),
		.cfg_deser_en_i(cfg_deser_en_i),
		.cfg_big_pkg_i(cfg_big_pkg_i),
		.cfg_lsrc_i(cfg_lsrc_i),
		.cfg_hsrc_i(cfg_hsrc_i),
		.cfg_ch_en_i(cfg_ch_en_i),
		.pll_tick_i(pll_tick_i),
		.rec_ls_tick_i(rec_ls_tick_i),
		.rec_hs_tick_i(rec_hs_tick_i),
		.running_o(running_o),
		.cfg_err_o(cfg_err_o),
		.bonded_o(bonded_o),
		.core_sel_o(core_sel_o),
		.core_clkout_o(core_clkout_o),
		.hs_sel_o(hs_sel_o),
		.ser_tick_o(ser_tick_o),
		.tx_pcs_tick_o(tx_pcs_tick_o),
		.tx_fifo_rd_tick_o(tx_fifo_rd_tick_o),
		.tx_clkout_o(tx_clkout_o),
		.deser_tick_o(deser_tick_o),
		.rm_wr_tick_o(rm_wr_tick_o),
		.rx_pcs_tick_o(rx_pcs_tick_o),
		.rx_fifo_wr_tick_o(rx_fifo_wr_tick_o),
		.rx_clkout_o(rx_clkout_o),
		.tx_rd_ptr_o(tx_rd_ptr_o),
		.rx_wr_ptr_o(rx_wr_ptr_o)
	);
	fabric_model u_fabric_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.core_clkout_i(core_clkout_o), .launch_cnt_o(launches));

	// Clock and halved-tick counters
	always #12.5 clk_sys_i = ~clk_sys_i;
	always @(negedge clk_sys_i) begin
		fn_t += (tx_fifo_rd_tick_o[0] === 1'b1);
		fn_r += (rx_fifo_wr_tick_o[0] === 1'b1);
	end

	////////////////////////////////////////////////////////////////////
	task chk(input logic [11:0] seen, input logic [11:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task final_report;
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Reset with a new configuration, wait four cycles, then check running
	task start(input logic [1:0] b, o, l, input logic r, s, g);
		cfg_bond_i = b;
		cfg_op_i = o;
		cfg_lsrc_i = l;
		cfg_rm_en_i = r;
		cfg_ser_en_i = s;
		cfg_deser_en_i = s;
		cfg_big_pkg_i = g;
		rst_n_i = 0;
		repeat (20) @(posedge clk_sys_i);
		#1 rst_n_i = 1;
		repeat (4) @(posedge clk_sys_i);
		#1 chk(running_o, 1);
	endtask

	// One-cycle tick pulses; returns one edge later
	task pulse(input logic [3:0] p, l, h);
		pll_tick_i = p;
		rec_ls_tick_i = l;
		rec_hs_tick_i = h;
		@(posedge clk_sys_i);
		#1 pll_tick_i = 0;
		rec_ls_tick_i = 0;
		rec_hs_tick_i = 0;
	endtask

	task train(input int n);
		fn_t = 0;
		fn_r = 0;
		repeat (n) begin
			@(posedge clk_sys_i);
			#1 pulse(4'h1, 0, 0);
		end
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////
	task t_x2_tx;
		start(1, 0, 0, 0, 0, 0);
		chk(bonded_o, 4'h3);
		chk(hs_sel_o, 8'h01);
		chk(core_sel_o, 2'h0);
		pulse(4'h1, 0, 0);
		chk(ser_tick_o[1:0], 2'h2);
		chk(tx_clkout_o, 4'hC);
		@(posedge clk_sys_i);
		#1 chk(core_clkout_o, 1);
		chk(tx_pcs_tick_o[1:0], 2'h3);
		chk(tx_fifo_rd_tick_o[1:0], 2'h3);
		cfg_bond_i = 2;
		train(3);
		chk(bonded_o, 4'h3);
		chk(tx_rd_ptr_o[5:0], 6'h24);
		chk(launches, 4);
		$display("x2 transmit test done");
	endtask

	task t_x4_rm;
		start(2, 2, 0, 1, 1, 0);
		chk(bonded_o, 4'hF);
		pulse(0, 4'hF, 4'hF);
		chk(deser_tick_o, 4'hF);
		chk(rm_wr_tick_o, 4'hF);
		train(4);
		chk(fn_t, 2);
		chk(fn_r, 2);
		chk(tx_rd_ptr_o, 12'h492);
		chk(rx_wr_ptr_o, 12'h492);
		pulse(4'h1, 0, 0);
		@(posedge clk_sys_i);
		#1 chk(rx_pcs_tick_o, 4'hF);
		chk(rx_clkout_o, 4'h0);
		$display("x4 rate-match test done");
	endtask

	task t_x2_norm;
		start(1, 2, 0, 0, 0, 0);
		pulse(0, 4'h5, 0);
		chk(rx_pcs_tick_o, 4'h5);
		chk(rx_clkout_o, 4'h5);
		chk(rx_fifo_wr_tick_o, 4'h5);
		$display("x2 no rate-match test done");
	endtask

	task t_err;
		for (int i = 0; i < 5; i++) begin
			start(tv[i][6:5], tv[i][4:3], tv[i][1:0], 0, 0, tv[i][2]);
			chk(cfg_err_o, ev[i]);
			chk(bonded_o, eb[i]);
			chk(core_sel_o, tv[i][1:0]);
		end
		cfg_hsrc_i = 8'h82;
		start(2, 0, 0, 0, 0, 1);
		chk(cfg_err_o, 1);
		chk(bonded_o, 4'h0);
		start(1, 0, 0, 0, 0, 1);
		chk(cfg_err_o, 0);
		chk(bonded_o, 4'h3);
		chk(hs_sel_o, 8'h82);
		start(1, 0, 0, 0, 0, 0);
		chk(cfg_err_o, 1);
		$display("refusal test done");
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys_i = 0;
		rst_n_i = 0;
		cfg_hsrc_i = 8'h01;
		cfg_ch_en_i = 4'hF;
		pll_tick_i = 0;
		rec_ls_tick_i = 0;
		rec_hs_tick_i = 0;
		t_x2_tx;
		t_x4_rm;
		t_x2_norm;
		t_err;
		final_report;
	end

	// Watchdog well beyond the expected run
	initial begin
		#200us;
		fails++;
		final_report;
	end
endmodule
